/* core/tmw_core.sv */
// Timer core: counter, flags, compare output state and pin override.
// Assumes i_tick is a one-cycle timer clock enable made elsewhere and
// that the register master keeps to the strobe protocol.
`timescale 1ns/100ps

module tmw_core (
  // Clock and reset
  input  wire logic                           i_clock,
  input  wire logic                           i_rst,
  // Timer clock enable
  input  wire logic                           i_tick,
  // Register port
  input  wire logic [tmw_pkg::TMW_ADDR_W-1:0] i_addr,
  input  wire logic [tmw_pkg::TMW_DATA_W-1:0] i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [tmw_pkg::TMW_DATA_W-1:0] o_rdata,
  // Output pin
  output logic                                o_pin_out,
  output logic                                o_pin_oe,
  // Status
  output logic                                o_compare_state,
  output logic                                o_overflow_flag,
  output logic                                o_compare_flag
);
  import tmw_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  tmw_top_state_type s;
  tmw_top_state_type next_s;
  tmw_cmp_if         cif ();

  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic at_max;
  logic pwm_mode;
  logic force_hit;
  logic set_ovf;
  logic set_cmp;

  // Applies a set, clear or toggle action to the output state
  function automatic logic apply_action(input logic [1:0] act,
                                        input logic       cur);
    logic res;
    res = cur;
    unique case (act)
      TMW_ACT_NONE:   res = cur;
      TMW_ACT_TOGGLE: res = !cur;
      TMW_ACT_CLEAR:  res = 1'b0;
      TMW_ACT_SET:    res = 1'b1;
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Compare value unit
  // ---------------------------------------------------------------
  tmw_cmp_unit u_cmp (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .cif     (cif)
  );

  // Count, block and pwm come from registered state; tick, wr and wdata come straight from the inputs
  assign cif.tick   = i_tick;
  assign cif.pwm    = pwm_mode;
  assign cif.wr     = wr_compare;
  assign cif.wdata  = i_wdata;
  assign cif.at_top = i_tick && at_max;
  assign cif.count  = s.count;
  assign cif.block  = s.block;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Only one strobe is high at a time, so no priority is needed
  assign wr_ctrl    = i_wr && (i_addr == TMW_ADDR_CTRL);
  assign wr_count   = i_wr && (i_addr == TMW_ADDR_COUNT);
  assign wr_compare = i_wr && (i_addr == TMW_ADDR_COMPARE);
  assign wr_flags   = i_wr && (i_addr == TMW_ADDR_FLAGS);
  assign at_max     = (s.count == TMW_COUNT_MAX);
  assign pwm_mode   = s.wave[0];

  // Force is honoured only when the newly written mode is non-PWM
  assign force_hit  = wr_ctrl && i_wdata[TMW_CTRL_FORCE_BIT]
                      && !i_wdata[TMW_CTRL_WAVE_LO];

  // Overflow on the step from max in every mode but TMW_WAVE_PHASE
  assign set_ovf    = i_tick && at_max
                      && (s.wave != TMW_WAVE_PHASE);
  // Counting sees the match one tick after the counter reached it
  assign set_cmp    = i_tick && cif.match;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Control fields; action mode acts from the next match on
    if (wr_ctrl) begin
      next_s.wave   = i_wdata[TMW_CTRL_WAVE_LO +: 2];
      next_s.action = i_wdata[TMW_CTRL_ACTION_LO +: 2];
      next_s.dir    = i_wdata[TMW_CTRL_DIR_BIT];
      next_s.port   = i_wdata[TMW_CTRL_PORT_BIT];
    end

    // Counter: sequence chosen by waveform mode and, in clear mode, the compare value
    if (i_tick) begin
      if (at_max) begin
        next_s.count = TMW_COUNT_BOTTOM;
      end else if ((s.wave == TMW_WAVE_CLEAR) && cif.match) begin
        next_s.count = TMW_COUNT_BOTTOM;
      end else begin
        next_s.count = s.count + 8'h01;
      end
    end

    // Match blocking lasts exactly one timer tick after a write
    if (wr_count) begin
      next_s.count = i_wdata;
      next_s.block = 1'b1;
    end else if (i_tick) begin
      next_s.block = 1'b0;
    end

    // Flags: a hardware set wins over a software clear
    next_s.ovf  = (s.ovf && !(wr_flags && i_wdata[TMW_FLAG_OVF_BIT]))
                  || set_ovf;
    next_s.cmpf = (s.cmpf && !(wr_flags && i_wdata[TMW_FLAG_CMP_BIT]))
                  || set_cmp;

    // Output state at timer ticks
    if (i_tick) begin
      unique case (s.wave)
        TMW_WAVE_NORMAL, TMW_WAVE_CLEAR: begin
          if (cif.match) begin
            next_s.ocs = apply_action(s.action, s.ocs);
          end
        end
        TMW_WAVE_FAST: begin
          if (s.action == TMW_ACT_TOGGLE) begin
            if (cif.match) begin
              next_s.ocs = !s.ocs;
            end
          end else if (s.action != TMW_ACT_NONE) begin
            // Bottom wins over a match at max: constant level
            if (at_max) begin
              next_s.ocs = (s.action == TMW_ACT_CLEAR);
            end else if (cif.match) begin
              next_s.ocs = (s.action == TMW_ACT_SET);
            end
          end
        end
        TMW_WAVE_PHASE: begin
          // Dual slope is not built; the output state simply holds
          next_s.ocs = s.ocs;
        end
      endcase
    end

    // Forced match: output only, no flag and no counter clear
    if (force_hit) begin
      next_s.ocs = apply_action(i_wdata[TMW_CTRL_ACTION_LO +: 2],
                                next_s.ocs);
    end

    // Read data stand only in the cycle after the read strobe
    next_s.rdata = TMW_RST_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        TMW_ADDR_CTRL:    next_s.rdata = {2'h0, s.port, s.dir,
                                          s.action, s.wave};
        TMW_ADDR_COUNT:   next_s.rdata = s.count;
        TMW_ADDR_COMPARE: next_s.rdata = cif.buffer;
        TMW_ADDR_FLAGS:   next_s.rdata = {6'h00, s.cmpf, s.ovf};
      endcase
    end

    // Pin override depends on action bits only, not waveform mode
    next_s.pin_out = (next_s.action != TMW_ACT_NONE)
                     ? next_s.ocs : next_s.port;
    next_s.pin_oe  = next_s.dir;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s        <= '0;
      s.ocs    <= TMW_RST_BIT;
      s.wave   <= TMW_RST_FIELD;
      s.action <= TMW_RST_FIELD;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All taken straight from the state register
  assign o_rdata         = s.rdata;
  assign o_pin_out       = s.pin_out;
  assign o_pin_oe        = s.pin_oe;
  assign o_compare_state = s.ocs;
  assign o_overflow_flag = s.ovf;
  assign o_compare_flag  = s.cmpf;

endmodule

/* core/tmw_pkg.sv */
// Constants, field layout and types of the 8-bit timer waveform block.
// Assumes nothing of its surroundings; shared by every core file.
package tmw_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned TMW_DATA_W = 8;
  localparam int unsigned TMW_ADDR_W = 2;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [TMW_ADDR_W-1:0] TMW_ADDR_CTRL    = 2'h0;
  localparam logic [TMW_ADDR_W-1:0] TMW_ADDR_COUNT   = 2'h1;
  localparam logic [TMW_ADDR_W-1:0] TMW_ADDR_COMPARE = 2'h2;
  localparam logic [TMW_ADDR_W-1:0] TMW_ADDR_FLAGS   = 2'h3;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned TMW_CTRL_WAVE_LO   = 0;
  localparam int unsigned TMW_CTRL_ACTION_LO = 2;
  localparam int unsigned TMW_CTRL_DIR_BIT   = 4;
  localparam int unsigned TMW_CTRL_PORT_BIT  = 5;
  localparam int unsigned TMW_CTRL_FORCE_BIT = 7;
  localparam int unsigned TMW_FLAG_OVF_BIT   = 0;
  localparam int unsigned TMW_FLAG_CMP_BIT   = 1;

  // ---------------------------------------------------------------
  // Waveform modes and output actions
  // ---------------------------------------------------------------
  localparam logic [1:0] TMW_WAVE_NORMAL = 2'h0;
  localparam logic [1:0] TMW_WAVE_PHASE  = 2'h1;
  localparam logic [1:0] TMW_WAVE_CLEAR  = 2'h2;
  localparam logic [1:0] TMW_WAVE_FAST   = 2'h3;
  localparam logic [1:0] TMW_ACT_NONE    = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR   = 2'h2;
  localparam logic [1:0] TMW_ACT_SET     = 2'h3;

  // ---------------------------------------------------------------
  // Counter limits and reset values
  // ---------------------------------------------------------------
  localparam logic [TMW_DATA_W-1:0] TMW_COUNT_MAX    = 8'hff;
  localparam logic [TMW_DATA_W-1:0] TMW_COUNT_BOTTOM = 8'h00;
  localparam logic [TMW_DATA_W-1:0] TMW_RST_BYTE     = 8'h00;
  localparam logic [1:0]            TMW_RST_FIELD    = 2'h0;
  localparam logic                  TMW_RST_BIT      = 1'b0;

  // ---------------------------------------------------------------
  // State records
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [TMW_DATA_W-1:0] buffer;
    logic [TMW_DATA_W-1:0] active;
  } tmw_cmp_state_type;

  typedef struct packed {
    logic [1:0]            wave;
    logic [1:0]            action;
    logic                  dir;
    logic                  port;
    logic [TMW_DATA_W-1:0] count;
    logic                  block;
    logic                  ovf;
    logic                  cmpf;
    logic                  ocs;
    logic [TMW_DATA_W-1:0] rdata;
    logic                  pin_out;
    logic                  pin_oe;
  } tmw_top_state_type;

endpackage

/* core/tmw_cmp_if.sv */
// Link between the timer core and its compare value unit.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tmw_cmp_if;
  import tmw_pkg::*;
  logic                  tick;
  logic                  pwm;
  logic                  wr;
  logic [TMW_DATA_W-1:0] wdata;
  logic                  at_top;
  logic [TMW_DATA_W-1:0] count;
  logic                  block;
  logic [TMW_DATA_W-1:0] buffer;
  logic [TMW_DATA_W-1:0] active;
  logic                  match;

  modport core (
    output tick, pwm, wr, wdata, at_top, count, block,
    input  buffer, active, match
  );
  modport unit (
    input  tick, pwm, wr, wdata, at_top, count, block,
    output buffer, active, match
  );
endinterface

/* core/tmw_cmp_unit.sv */
// Compare value holder: write buffer, active value and comparator.
// Assumes the core drives count and block from its own registers.
`timescale 1ns/100ps
module tmw_cmp_unit (
  // Clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst,
  // Link to the core
  tmw_cmp_if.unit    cif
);
  import tmw_pkg::*;

  tmw_cmp_state_type s;
  tmw_cmp_state_type next_s;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // PWM modes defer the active value to top so no odd pulse appears
  always_comb begin
    next_s = s;
    if (cif.wr) begin
      next_s.buffer = cif.wdata;
    end
    if (cif.wr && !cif.pwm) begin
      next_s.active = cif.wdata;
    end else if (cif.pwm && cif.at_top) begin
      next_s.active = s.buffer;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Comparator; a counter write masks one timer cycle of matches
  assign cif.match  = (cif.count == s.active) && !cif.block;
  assign cif.buffer = s.buffer;
  assign cif.active = s.active;

endmodule

/* tb/tmw_core_props.sv */
// Checker for the timer waveform core, seen at its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tmw_core_props (
  // Clock, reset and inputs
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_tick,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  // Outputs
  input wire logic [7:0] o_rdata,
  input wire logic       o_pin_out,
  input wire logic       o_pin_oe,
  input wire logic       o_compare_state,
  input wire logic       o_overflow_flag,
  input wire logic       o_compare_flag
);
  logic [1:0] act;
  logic       prt;
  logic       cw;
  assign cw = i_wr && i_addr == 2'h0;
  // Shadow of action bits and port bit, so the pin mux can be judged
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      act <= 2'h0;
      prt <= 1'b0;
    end else if (cw) begin
      act <= i_wdata[3:2];
      prt <= i_wdata[5];
    end
  end
  default clocking dc @(posedge i_clock); endclocking
  a_reset_ocs: assert property (i_rst |=> !o_compare_state)
    else $error("state kept over reset");
  a_pin_mux: assert property (disable iff (i_rst)
    o_pin_out == (act != 2'h0 ? o_compare_state : prt))
    else $error("pin source wrong");
  a_pin_enable: assert property (disable iff (i_rst)
    cw |=> o_pin_oe == $past(i_wdata[4])) else $error("pin enable wrong");
  a_ovf_sticky: assert property (disable iff (i_rst)
    o_overflow_flag && !(i_wr && i_addr == 2'h3 && i_wdata[0])
    |=> o_overflow_flag) else $error("overflow lost");
  a_idle_holds: assert property (disable iff (i_rst)
    !i_tick && !i_wr |=> $stable({o_compare_state, o_overflow_flag,
    o_compare_flag})) else $error("change without tick");
  a_cmp_on_tick: assert property (disable iff (i_rst)
    $rose(o_compare_flag) |-> $past(i_tick)) else $error("flag off tick");
  a_ovf_on_tick: assert property (disable iff (i_rst)
    $rose(o_overflow_flag) |-> $past(i_tick)) else $error("ovf off tick");
  a_force_no_flag: assert property (disable iff (i_rst)
    cw && i_wdata[7] && !i_tick && !o_compare_flag |=> !o_compare_flag)
    else $error("force set flag");
  a_count_write: assert property (disable iff (i_rst)
    (i_wr && i_addr == 2'h1) ##1 (i_rd && i_addr == 2'h1 && !i_tick)
    |=> o_rdata == $past(i_wdata, 2)) else $error("count write lost");
endmodule
bind tmw_core tmw_core_props u_tmw_core_props (.*);

/* tb/tmw_pin_model.sv */
// Board pin seen by the core: a pull-up, driven only when enabled.
// Assumes the enable is high while the core drives the pin.
`timescale 1ns/100ps
module tmw_pin_model (
  // From the core
  input  wire logic i_drive,
  input  wire logic i_enable,
  // Level on the board
  output logic      o_level
);
  // Released pin goes to the pull-up, never keeps the last level
  assign o_level = i_enable ? i_drive : 1'b1;
endmodule

/* tb/tmw_core_tb_top.sv */
// Bench for the timer waveform core: drives registers and ticks, and
// checks every output against a bench model in every cycle out of reset.
// Assumes the package, core, checker and pin model are compiled.
`timescale 1ns/100ps
module tmw_core_tb_top;
  import tmw_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_tick = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       o_pin_out;
  logic       o_pin_oe;
  logic       o_compare_state;
  logic       o_overflow_flag;
  logic       o_compare_flag;
  logic       pin_level;
  logic       hit;
  logic       top;
  logic [7:0] cmp;
  logic [1:0] mds[3] = '{TMW_WAVE_NORMAL, TMW_WAVE_CLEAR, TMW_WAVE_FAST};
  logic [7:0] frc[6] = '{8'h9c, 8'h94, 8'h94, 8'h98, 8'h90, 8'h9f};
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         r;
  int         m_wave, m_act, m_dir, m_port, m_cnt, m_buf, m_actv;
  int         m_blk, m_ovf, m_cmpf, m_ocs, m_rd, e_pin;

  tmw_core u_tmw_core (
    .i_clock         (i_clock),
    .i_rst           (i_rst),
    .i_tick          (i_tick),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .o_pin_out       (o_pin_out),
    .o_pin_oe        (o_pin_oe),
    .o_compare_state (o_compare_state),
    .o_overflow_flag (o_overflow_flag),
    .o_compare_flag  (o_compare_flag)
  );
  tmw_pin_model u_tmw_pin_model (.i_drive(o_pin_out), .i_enable(o_pin_oe),
                                 .o_level(pin_level));

  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One bus cycle; ticks are kept off during accesses
  task automatic cyc(input logic w, input logic rd, input logic [1:0] a,
                     input logic [7:0] d, input logic t);
    i_wr <= w;
    i_rd <= rd;
    i_addr <= a;
    i_wdata <= d;
    i_tick <= t;
    @(posedge i_clock);
  endtask

  function automatic int f_act(int a, int s);
    return a == 1 ? !s : a == 2 ? 0 : a == 3 ? 1 : s;
  endfunction

  // Model steps on the same edge, from the values the core samples
  always @(posedge i_clock) begin
    m_rd = 0;
    if (i_rst) begin
      {m_wave, m_act, m_dir, m_port, m_cnt, m_buf, m_actv, m_blk, m_ovf,
       m_cmpf, m_ocs} = '0;
    end else begin
      if (i_rd)
        case (i_addr)
          2'h0: m_rd = m_port * 32 + m_dir * 16 + m_act * 4 + m_wave;
          2'h1: m_rd = m_cnt;
          2'h2: m_rd = m_buf;
          default: m_rd = m_cmpf * 2 + m_ovf;
        endcase
      if (i_tick) begin
        hit = m_cnt == m_actv && !m_blk;
        top = m_cnt == 255;
        m_blk = 0;
        m_cmpf = m_cmpf | hit;
        // Dual slope mode is not built: no overflow, output holds
        m_ovf = m_ovf | (top && m_wave != 1);
        if (hit && m_wave != 1)
          m_ocs = f_act(m_act, m_ocs);
        if (m_wave == 3 && top && m_act > 1) m_ocs = m_act == 2;
        if (m_wave % 2 == 1 && top) m_actv = m_buf;
        m_cnt = m_wave == 2 && hit ? 0 : (m_cnt + 1) % 256;
      end
      if (i_wr)
        case (i_addr)
          2'h0: begin
            m_wave = i_wdata[1:0];
            m_act = i_wdata[3:2];
            m_dir = i_wdata[4];
            m_port = i_wdata[5];
            if (i_wdata[7] && !i_wdata[0]) m_ocs = f_act(m_act, m_ocs);
          end
          2'h1: begin
            m_cnt = i_wdata;
            m_blk = 1;
          end
          2'h2: begin
            m_buf = i_wdata;
            if (m_wave % 2 == 0) m_actv = i_wdata;
          end
          default: begin
            if (i_wdata[0]) m_ovf = 0;
            if (i_wdata[1]) m_cmpf = 0;
          end
        endcase
    end
  end

  // Outputs are settled mid-cycle, so compare on the falling edge
  always @(negedge i_clock) begin
    if (!i_rst) begin
      e_pin = m_act != 0 ? m_ocs : m_port;
      chk(o_rdata, m_rd[7:0]);
      chk(o_compare_state, m_ocs[0]);
      chk(o_overflow_flag, m_ovf[0]);
      chk(o_compare_flag, m_cmpf[0]);
      chk(o_pin_oe, m_dir[0]);
      chk(o_pin_out, e_pin[0]);
      chk(pin_level, m_dir != 0 ? e_pin[0] : 1'b1);
    end
  end

  // Cuts a hung run short
  initial begin
    repeat (100000) @(posedge i_clock);
    n_mismatch++;
    stop_test;
  end

  initial begin
    void'($urandom(40));
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    // Force strobes in normal mode; the last one is in fast PWM
    foreach (frc[i]) begin
      cyc(1, 0, 2'h0, frc[i], 0);
      cyc(0, 1, 2'h0, 8'h00, 0);
    end
    cyc(1, 0, 2'h0, 8'h9c, 0);
    i_rst <= 1'b1;
    repeat (2) cyc(0, 0, 2'h0, 8'h00, 0);
    i_rst <= 1'b0;
    $display("test force and reset done");
    foreach (mds[mi])
      for (int a = 0; a < 4; a++)
        for (int c = 0; c < 3; c++) begin
          cmp = c == 0 ? 8'h00 : c == 1 ? 8'hff : 8'($urandom);
          cyc(1, 0, 2'h2, cmp, 0);
          cyc(1, 0, 2'h0, {2'($urandom), 2'($urandom), 2'(a), mds[mi]}, 0);
          cyc(1, 0, 2'h1, 8'($urandom), 0);
          cyc(0, 1, 2'h1, 8'h00, 0);
          repeat (600) begin
            r = $urandom % 32;
            if (r < 4)
              cyc(r != 1, r == 1, r == 1 ? 2'($urandom) : 2'(r + 1),
                  8'($urandom), 0);
            else
              cyc(0, 0, 2'h0, 8'h00, r > 9);
          end
          $display("test mode %0d action %0d case %0d done", mds[mi], a, c);
        end
    cyc(0, 0, 2'h0, 8'h00, 0);
    stop_test;
  end
endmodule
